/* File: tcc_defines.svh */
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
// Functional notes
// [RULE1] A counter write blocks any compare match in the next timer tick.
// [RULE2] Writing count equal to variable top skips that top; counter runs to max.
// [RULE3] Software must not write bottom while counting down.
// [RULE4] Output latch keeps its value across waveform mode changes.
// [RULE5] Output action bits act directly, from the first match after writing.
// [RULE6] Reset clears every output latch to zero.
// [RULE7] Nonzero action puts the latch on the pin instead of port value.
// [RULE8] Pin is driven only while its direction bit selects output.
// [RULE9] Output action bits never affect the capture flag.
// [RULE10] Action zero leaves the latch unchanged on a match.
// [RULE11] Force strobe in non-PWM modes applies the action at once.
// [RULE12] Counting depends on mode only; action selects pin behaviour only.
// [RULE13] Mode 0 always increments, wrapping from max to zero.
// [RULE14] Overflow flag sets when count rolls from max to zero; ack or write-one clears.
// [RULE15] Normal mode accepts a counter write at any time.
// [RULE16] Clear-on-match mode clears count at top: compare A (4) or capture (12).
// [RULE17] Top has no double buffer; a low top waits for the wrap.
// [RULE18] Top match sets compare A flag or capture flag, per top source.
// [RULE19] Channel A action 1 in clear-on-match mode toggles each match.
// [RULE20] Prescaler divides the clock by 1, 8, 64, 256 or 1024.
// [RULE21] Clear-on-match mode sets overflow on the roll from max to zero.
// [RULE22] Equality sets the channel flag next tick; ack or write-one clears.
// [RULE23] Forced compare touches neither flag nor counter, only the latch.
// [RULE24] Non-PWM actions 1, 2, 3 toggle, clear, set the latch.
`define TCC_MODE_NORMAL 4'h0
`define TCC_MODE_CTC_A 4'h4
`define TCC_MODE_CTC_CAP 4'hC
`define TCC_MODE_FAST_CAP 4'hE
`define TCC_MODE_FAST_A 4'hF
`define TCC_ACT_NONE 2'h0
`define TCC_ACT_TOGGLE 2'h1
`define TCC_ACT_CLEAR 2'h2
`define TCC_ACT_SET 2'h3
`define TCC_CS_STOP 3'h0
`define TCC_CS_DIV1 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_MASK_DIV1 10'h000
`define TCC_MASK_DIV8 10'h007
`define TCC_MASK_DIV64 10'h03F
`define TCC_MASK_DIV256 10'h0FF
`define TCC_MASK_DIV1024 10'h3FF
`define TCC_COUNT_MAX 16'hFFFF
`define TCC_COUNT_BOTTOM 16'h0000
`define TCC_COUNT_WIDTH 16
`endif

/* File: tcc_pin_load.sv */
`timescale 1ns/1ns
module tcc_pin_load (
  input wire logic mclk,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe,
  output logic [1:0] pin_level
);
  logic [1:0] last_driven = 2'h0;
  // Undriven pin floats: show the inverse of the last driven level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ~last_driven[i];
    end
  end
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (pin_oe[i]) begin
        last_driven[i] <= pin_out[i];
      end
    end
  end
endmodule

/* File: tcc_pkg.sv */
package tcc_pkg;
  typedef logic [1:0] tcc_action_type;
  typedef logic [3:0] tcc_mode_type;
  typedef logic [15:0] tcc_word_type;
  typedef logic [9:0] tcc_prescale_type;
endpackage

/* File: tcc_timer16.sv */
`timescale 1ns/1ns
`include "tcc_defines.svh"
module tcc_timer16
  import tcc_pkg::*;
#(
  parameter int COUNT_WIDTH = `TCC_COUNT_WIDTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] clock_select,
  input wire tcc_mode_type waveform_mode_select,
  input wire tcc_action_type channel_a_output_action,
  input wire tcc_action_type channel_b_output_action,
  input wire logic count_write,
  input wire tcc_word_type count_write_data,
  input wire tcc_word_type channel_a_compare_value,
  input wire tcc_word_type channel_b_compare_value,
  input wire tcc_word_type capture_top_value,
  input wire logic [1:0] force_strobe,
  input wire logic [1:0] match_flag_clear,
  input wire logic overflow_flag_clear,
  input wire logic capture_flag_clear,
  input wire logic [1:0] port_output_value,
  input wire logic [1:0] output_pin_direction_bit,
  output tcc_word_type timer_count_value,
  output logic counter_overflow_flag,
  output logic capture_event_flag,
  output wire logic [1:0] channel_match_flag,
  output wire logic [1:0] compare_output_latch,
  output wire logic [1:0] pin_out,
  output wire logic [1:0] pin_oe
);

  if (COUNT_WIDTH != `TCC_COUNT_WIDTH) begin : g_bad_width
    $error("tcc_timer16 supports only a 16-bit counter");
  end

  tcc_prescale_type prescale_count;
  tcc_prescale_type next_prescale_count;
  tcc_prescale_type prescale_mask;
  logic tick;
  logic block_pending;
  logic next_block_pending;
  tcc_word_type next_count;
  logic next_overflow_flag;
  logic next_capture_flag;
  logic variable_top;
  logic top_is_capture;
  logic non_pwm;
  logic top_match;
  tcc_word_type top_value;
  wire logic [1:0] match_hit;
  tcc_action_type action [2];
  tcc_word_type compare [2];

  assign action[0] = channel_a_output_action;
  assign action[1] = channel_b_output_action;
  assign compare[0] = channel_a_compare_value;
  assign compare[1] = channel_b_compare_value;

  // Timer tick from the prescaler
  always_comb begin
    case (clock_select) // RULE20
      `TCC_CS_DIV1: prescale_mask = `TCC_MASK_DIV1;
      `TCC_CS_DIV8: prescale_mask = `TCC_MASK_DIV8;
      `TCC_CS_DIV64: prescale_mask = `TCC_MASK_DIV64;
      `TCC_CS_DIV256: prescale_mask = `TCC_MASK_DIV256;
      `TCC_CS_DIV1024: prescale_mask = `TCC_MASK_DIV1024;
      default: prescale_mask = `TCC_MASK_DIV1;
    endcase
    tick = (clock_select >= `TCC_CS_DIV1)
      && (clock_select <= `TCC_CS_DIV1024)
      && ((prescale_count & prescale_mask) == prescale_mask);
    next_prescale_count = prescale_count + 10'h001;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prescale_count <= 10'h000;
    end else begin
      prescale_count <= next_prescale_count;
    end
  end

  // Counter, top detection and the shared flags
  always_comb begin
    non_pwm = (waveform_mode_select == `TCC_MODE_NORMAL)
      || (waveform_mode_select == `TCC_MODE_CTC_A)
      || (waveform_mode_select == `TCC_MODE_CTC_CAP);
    top_is_capture = (waveform_mode_select == `TCC_MODE_CTC_CAP)
      || (waveform_mode_select == `TCC_MODE_FAST_CAP);
    variable_top = top_is_capture
      || (waveform_mode_select == `TCC_MODE_CTC_A)
      || (waveform_mode_select == `TCC_MODE_FAST_A);
    top_value = top_is_capture ? capture_top_value
      : channel_a_compare_value; // RULE17
    top_match = tick && !block_pending && variable_top
      && (timer_count_value == top_value); // RULE2 RULE16
    next_count = timer_count_value;
    next_block_pending = block_pending;
    if (count_write) begin
      next_count = count_write_data; // RULE15
      next_block_pending = 1'b1; // RULE1
    end else if (tick) begin
      next_block_pending = 1'b0;
      if (top_match) begin
        next_count = `TCC_COUNT_BOTTOM; // RULE16
      end else begin
        next_count = timer_count_value + `TCC_COUNT_WIDTH'(1); // RULE13
      end
    end
    next_overflow_flag = (tick && !count_write
      && timer_count_value == `TCC_COUNT_MAX) // RULE14 RULE21
      || (counter_overflow_flag && !overflow_flag_clear);
    next_capture_flag = (top_match && top_is_capture) // RULE18 RULE9
      || (capture_event_flag && !capture_flag_clear);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      timer_count_value <= `TCC_COUNT_BOTTOM;
      block_pending <= 1'b0;
      counter_overflow_flag <= 1'b0;
      capture_event_flag <= 1'b0;
    end else begin
      timer_count_value <= next_count;
      block_pending <= next_block_pending;
      counter_overflow_flag <= next_overflow_flag;
      capture_event_flag <= next_capture_flag;
    end
  end

  // Per-channel compare, output latch and pin override
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic latch;
    logic next_latch;
    logic flag;
    logic next_flag;
    logic pin;
    logic next_pin;
    logic oe;
    logic apply;

    assign match_hit[ch] = tick && !block_pending // RULE1
      && (timer_count_value == compare[ch]);

    always_comb begin
      // Force acts like a match on the latch only
      apply = (match_hit[ch] || force_strobe[ch]) && non_pwm; // RULE11
      next_latch = latch; // RULE4
      if (apply) begin
        case (action[ch]) // RULE5 RULE12 RULE24
          `TCC_ACT_TOGGLE: next_latch = !latch; // RULE19
          `TCC_ACT_CLEAR: next_latch = 1'b0;
          `TCC_ACT_SET: next_latch = 1'b1;
          default: next_latch = latch; // RULE10
        endcase
      end
      next_flag = match_hit[ch] // RULE22 RULE23
        || (flag && !match_flag_clear[ch]);
      next_pin = (action[ch] != `TCC_ACT_NONE) ? next_latch
        : port_output_value[ch]; // RULE7
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        latch <= 1'b0; // RULE6
        flag <= 1'b0;
        pin <= 1'b0;
        oe <= 1'b0;
      end else begin
        latch <= next_latch;
        flag <= next_flag;
        pin <= next_pin;
        oe <= output_pin_direction_bit[ch]; // RULE8
      end
    end

    assign compare_output_latch[ch] = latch;
    assign channel_match_flag[ch] = flag;
    assign pin_out[ch] = pin;
    assign pin_oe[ch] = oe;
  end

  property p_write_sets_block;
    @(posedge mclk) disable iff (rst)
      count_write |=> block_pending;
  endproperty
  a_write_sets_block: assert property (p_write_sets_block) // RULE1
    else $error("Counter write did not arm match blocking");

  property p_block_no_match;
    @(posedge mclk) disable iff (rst)
      (block_pending && tick && !count_write)
      |=> timer_count_value == $past(timer_count_value)
          + `TCC_COUNT_WIDTH'(1)
        && (channel_match_flag & ~$past(channel_match_flag)) == 2'h0;
  endproperty
  a_block_no_match: assert property (p_block_no_match) // RULE1 RULE2
    else $error("Compare match seen while blocked");

  property p_wrap_overflow;
    @(posedge mclk) disable iff (rst)
      (tick && !count_write && !top_match
        && timer_count_value == `TCC_COUNT_MAX)
      |=> counter_overflow_flag
        && timer_count_value == `TCC_COUNT_BOTTOM;
  endproperty
  a_wrap_overflow: assert property (p_wrap_overflow) // RULE13 RULE14 RULE21
    else $error("Wrap to zero without overflow flag");

  property p_top_clear;
    @(posedge mclk) disable iff (rst)
      (top_match && !count_write)
      |=> timer_count_value == `TCC_COUNT_BOTTOM;
  endproperty
  a_top_clear: assert property (p_top_clear) // RULE16
    else $error("Counter not cleared at top");

  property p_capture_flag;
    @(posedge mclk) disable iff (rst)
      (top_match && top_is_capture) |=> capture_event_flag;
  endproperty
  a_capture_flag: assert property (p_capture_flag) // RULE18
    else $error("Capture flag missing at top");

  property p_match_flag;
    @(posedge mclk) disable iff (rst)
      match_hit[0] |=> channel_match_flag[0];
  endproperty
  a_match_flag: assert property (p_match_flag) // RULE22
    else $error("Match did not set channel flag");

  property p_force_no_flag;
    @(posedge mclk) disable iff (rst)
      (force_strobe[0] && !match_hit[0] && !channel_match_flag[0]
        && !count_write && !tick) |=> !channel_match_flag[0]
        && $stable(timer_count_value);
  endproperty
  a_force_no_flag: assert property (p_force_no_flag) // RULE23
    else $error("Force touched flag or counter");

  property p_toggle;
    @(posedge mclk) disable iff (rst)
      (match_hit[0] && non_pwm
        && channel_a_output_action == `TCC_ACT_TOGGLE)
      |=> compare_output_latch[0] != $past(compare_output_latch[0]);
  endproperty
  a_toggle: assert property (p_toggle) // RULE19 RULE24
    else $error("Latch did not toggle on match");

  property p_zero_action;
    @(posedge mclk) disable iff (rst)
      (channel_a_output_action == `TCC_ACT_NONE)
      |=> $stable(compare_output_latch[0]);
  endproperty
  a_zero_action: assert property (p_zero_action) // RULE10 RULE4
    else $error("Latch changed with action zero");

  property p_pin_source;
    @(posedge mclk) disable iff (rst)
      (channel_a_output_action != `TCC_ACT_NONE)
      |=> pin_out[0] == compare_output_latch[0];
  endproperty
  a_pin_source: assert property (p_pin_source) // RULE7
    else $error("Pin not driven from output latch");

  property p_pin_dir;
    @(posedge mclk) disable iff (rst)
      ##1 pin_oe[1] == $past(output_pin_direction_bit[1]);
  endproperty
  a_pin_dir: assert property (p_pin_dir) // RULE8
    else $error("Pin enable does not follow direction bit");

  property p_force_set;
    @(posedge mclk) disable iff (rst)
      (force_strobe[0] && non_pwm
        && channel_a_output_action == `TCC_ACT_SET)
      |=> compare_output_latch[0];
  endproperty
  a_force_set: assert property (p_force_set) // RULE11
    else $error("Force did not set the output latch");

  property p_pwm_hold;
    @(posedge mclk) disable iff (rst)
      !non_pwm |=> $stable(compare_output_latch);
  endproperty
  a_pwm_hold: assert property (p_pwm_hold) // RULE4
    else $error("Output latch changed in a PWM mode");

  property p_stop_hold;
    @(posedge mclk) disable iff (rst)
      (clock_select == `TCC_CS_STOP && !count_write)
      |=> $stable(timer_count_value);
  endproperty
  a_stop_hold: assert property (p_stop_hold) // RULE20
    else $error("Counter moved while the timer clock is stopped");

  property p_count_step;
    @(posedge mclk) disable iff (rst)
      (waveform_mode_select == `TCC_MODE_NORMAL && tick && !count_write)
      |=> timer_count_value == $past(timer_count_value)
          + `TCC_COUNT_WIDTH'(1);
  endproperty
  a_count_step: assert property (p_count_step) // RULE13 RULE12
    else $error("Normal mode tick did not increment the counter");

  property p_flag_clear;
    @(posedge mclk) disable iff (rst)
      (match_flag_clear[0] && !match_hit[0])
      |=> !channel_match_flag[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) // RULE22
    else $error("Channel flag not cleared by clear pulse");

endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
`include "tcc_defines.svh"
module testbench;
  import tcc_pkg::*;
  logic mclk = 0;
  logic rst = 1;
  logic [2:0] cs = 0;
  tcc_mode_type mode = 0;
  tcc_action_type act_a = 0;
  tcc_action_type act_b = 0;
  logic cw = 0;
  logic oclr = 0;
  logic cclr = 0;
  tcc_word_type cwd = 0;
  tcc_word_type cmp_a = 16'h1000;
  tcc_word_type cmp_b = 16'h1000;
  tcc_word_type top = 16'h1000;
  logic [1:0] frc_s = 0;
  logic [1:0] mclr = 0;
  logic [1:0] port_v = 0;
  logic [1:0] dir = 0;
  logic [1:0] mflag, latch, pout, poe, lvl;
  logic ovf, capf, l0, ex;
  tcc_word_type cnt;
  int num_errors = 0;
  int check_count = 0;
  always #4 mclk = ~mclk;
  tcc_timer16 DUT (.mclk(mclk), .rst(rst), .clock_select(cs),
    .waveform_mode_select(mode), .channel_a_output_action(act_a),
    .channel_b_output_action(act_b), .count_write(cw),
    .count_write_data(cwd), .channel_a_compare_value(cmp_a),
    .channel_b_compare_value(cmp_b), .capture_top_value(top),
    .force_strobe(frc_s), .match_flag_clear(mclr),
    .overflow_flag_clear(oclr), .capture_flag_clear(cclr),
    .port_output_value(port_v), .output_pin_direction_bit(dir),
    .timer_count_value(cnt), .counter_overflow_flag(ovf),
    .capture_event_flag(capf), .channel_match_flag(mflag),
    .compare_output_latch(latch), .pin_out(pout), .pin_oe(poe));
  tcc_pin_load load (.mclk(mclk), .pin_out(pout), .pin_oe(poe),
    .pin_level(lvl));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr_cnt(input tcc_word_type d);
    cw = 1;
    cwd = d;
    cyc(1);
    cw = 0;
    cyc(1);
  endtask
  task automatic frc(input tcc_action_type a);
    act_a = a;
    frc_s = 2'h1;
    cyc(1);
    frc_s = 0;
    cyc(1);
  endtask
  task automatic clr;
    mclr = 2'h3;
    oclr = 1;
    cclr = 1;
    cyc(1);
    mclr = 0;
    oclr = 0;
    cclr = 0;
    cyc(1);
  endtask
  task automatic finish_test;
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(10000);
    num_errors++;
    finish_test();
  end
  // Up-counting modes only, so bottom writes are safe
  initial begin
    cyc(8);
    rst = 0;
    chk({ovf, capf, mflag, latch, pout, poe}, 0);
    chk(cnt, 0);
    cs = `TCC_CS_DIV1;
    wr_cnt(16'hfffe);
    chk({cnt, ovf}, {16'hffff, 1'b0});
    cyc(1);
    chk({cnt, ovf}, {16'h0000, 1'b1});
    cmp_b = 16'h0050;
    clr();
    wr_cnt(16'h0050);
    chk({cnt, mflag[1], ovf}, {16'h0051, 1'b0, 1'b0});
    wr_cnt(16'h004f);
    cyc(1);
    chk({cnt, mflag[1]}, {16'h0051, 1'b1});
    cs = `TCC_CS_STOP;
    clr();
    frc(`TCC_ACT_CLEAR);
    chk(latch[0], 0);
    frc(`TCC_ACT_SET);
    chk(latch[0], 1);
    frc(`TCC_ACT_TOGGLE);
    chk(latch[0], 0);
    frc(`TCC_ACT_SET);
    chk({cnt, mflag}, {16'h0051, 2'h0});
    mode = `TCC_MODE_CTC_CAP;
    cyc(1);
    mode = `TCC_MODE_NORMAL;
    cyc(1);
    chk(latch[0], 1);
    mode = `TCC_MODE_CTC_A;
    cmp_a = 16'h0002;
    act_a = `TCC_ACT_TOGGLE;
    dir = 2'h1;
    cs = `TCC_CS_DIV1;
    wr_cnt(0);
    clr();
    l0 = latch[0];
    for (int k = 4; k < 10; k++) begin
      cyc(1);
      chk(cnt, 16'(k % 3));
      chk(latch[0], l0 ^ ((k / 3) % 2 == 0));
    end
    chk({mflag[0], poe[0], lvl[0]}, {1'b1, 1'b1, latch[0]});
    act_a = `TCC_ACT_NONE;
    port_v = ~latch;
    l0 = latch[0];
    cyc(3);
    chk({latch[0], pout[0]}, {l0, port_v[0]});
    ex = ~latch[0];
    act_a = ex ? `TCC_ACT_SET : `TCC_ACT_CLEAR;
    cyc(3);
    chk(latch[0], ex);
    dir = 0;
    cyc(2);
    chk(poe[0], 0);
    mode = `TCC_MODE_CTC_CAP;
    top = 16'h0003;
    cmp_a = 16'h1000;
    wr_cnt(0);
    clr();
    chk({cnt, capf}, {16'h0003, 1'b0});
    cyc(1);
    chk({cnt, capf}, {16'h0000, 1'b1});
    clr();
    wr_cnt(16'hfffe);
    cyc(1);
    chk({cnt, ovf, capf}, {16'h0000, 1'b1, 1'b0});
    mode = `TCC_MODE_FAST_CAP;
    wr_cnt(16'h0003);
    chk(cnt, 16'h0004);
    mode = `TCC_MODE_NORMAL;
    for (int i = 1; i < 6; i++) begin
      cs = 3'(i);
      wr_cnt(0);
      cyc(2 * (1 << (3 * (i - 1) - (i > 3 ? i - 3 : 0) * 1)) - 1);
      chk(cnt, 16'h0002);
    end
    finish_test();
  end
endmodule
